// [gptb_pkg.sv]
// Package with register map, field layout and mode codes for the timer block.
package gptb_pkg;
   localparam int          GPTB_AW            = 8;
   localparam logic [7:0]  GPTB_OFS_PID       = 8'h00;
   localparam logic [7:0]  GPTB_OFS_EMU       = 8'h04;
   localparam logic [7:0]  GPTB_OFS_CNT_LO    = 8'h10;
   localparam logic [7:0]  GPTB_OFS_CNT_HI    = 8'h14;
   localparam logic [7:0]  GPTB_OFS_PRD_LO    = 8'h18;
   localparam logic [7:0]  GPTB_OFS_PRD_HI    = 8'h1C;
   localparam logic [7:0]  GPTB_OFS_TCTL      = 8'h20;
   localparam logic [7:0]  GPTB_OFS_GCTL      = 8'h24;
   localparam logic [7:0]  GPTB_OFS_WDCTL     = 8'h28;
   localparam logic [7:0]  GPTB_OFS_REL_LO    = 8'h34;
   localparam logic [7:0]  GPTB_OFS_REL_HI    = 8'h38;
   localparam logic [7:0]  GPTB_OFS_CAP_LO    = 8'h3C;
   localparam logic [7:0]  GPTB_OFS_CAP_HI    = 8'h40;
   localparam logic [7:0]  GPTB_OFS_INTST     = 8'h44;
   // Identification value is arbitrary.
   localparam logic [31:0] GPTB_PID_VALUE     = 32'h0000_0A01;
   // Timer control fields: per half, mode at [1:0] / [17:16].
   localparam int          GPTB_TC_MODE_LO    = 0;
   localparam int          GPTB_TC_MODE_HI    = 16;
   localparam int          GPTB_TC_EXTCLK     = 8;
   localparam int          GPTB_TC_CAPEN      = 11;
   localparam int          GPTB_TC_RDRST      = 10;
   // Global control fields.
   localparam int          GPTB_GC_RS_LO      = 0;
   localparam int          GPTB_GC_RS_HI      = 1;
   localparam int          GPTB_GC_TMODE      = 2;
   // Watchdog control fields and service keys.
   localparam int          GPTB_WD_EN         = 14;
   localparam int          GPTB_WD_FLAG       = 15;
   localparam logic [15:0] GPTB_WD_KEY1       = 16'hA5C6;
   localparam logic [15:0] GPTB_WD_KEY2       = 16'hDA7E;
   // Status bits: low event, high event, capture flag.
   localparam int          GPTB_ST_EVT_LO     = 0;
   localparam int          GPTB_ST_EVT_HI     = 1;
   localparam int          GPTB_ST_CAP        = 2;
   localparam logic [1:0]  GPTB_MD_OFF        = 2'h0;
   localparam logic [1:0]  GPTB_MD_ONCE       = 2'h1;
   localparam logic [1:0]  GPTB_MD_CONT       = 2'h2;
   localparam logic [1:0]  GPTB_MD_RELOAD     = 2'h3;
   localparam logic [1:0]  GPTB_TM_64         = 2'h0;
   localparam logic [1:0]  GPTB_TM_DUAL       = 2'h1;
   localparam logic [1:0]  GPTB_TM_WDOG       = 2'h2;
   localparam logic [1:0]  GPTB_TM_CHAIN      = 2'h3;
   typedef enum logic [2:0] {
      GPTB_WS_IDLE  = 3'b001,
      GPTB_WS_ARMED = 3'b010,
      GPTB_WS_RUN   = 3'b100
   } gptb_wdst_e;
endpackage : gptb_pkg

// [gptb_timer.sv]
// General purpose timer with chaining, reload, capture and watchdog.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module gptb_timer #(
   parameter int HAS_EXT = 1
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [gptb_pkg::GPTB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       tim_in_i,
   output logic      [1:0]                 irq_o,
   output logic      [1:0]                 dma_evt_o,
   output logic                            rto_evt_o,
   output logic                            wdog_rst_o
);
   import gptb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [31:0] cnt_lo_r, cnt_hi_r, prd_lo_r, prd_hi_r;
   logic [31:0] rel_lo_r, rel_hi_r, cap_lo_r, cap_hi_r;
   logic [31:0] tctl_r, gctl_r, emu_r;
   logic [15:0] wdkey_r;
   logic        wdflag_r;
   logic [2:0]  stat_r;
   logic [2:0]  pin_r;
   logic        pin_lvl_r;
   logic        done_lo_r, done_hi_r;
   gptb_wdst_e  wst_r;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.
   wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr      = req & wb_we_i;
   wire rd      = req & ~wb_we_i;
   wire a_cl    = wb_adr_i == GPTB_OFS_CNT_LO;
   wire a_ch    = wb_adr_i == GPTB_OFS_CNT_HI;
   wire a_pl    = wb_adr_i == GPTB_OFS_PRD_LO;
   wire a_ph    = wb_adr_i == GPTB_OFS_PRD_HI;
   wire a_tc    = wb_adr_i == GPTB_OFS_TCTL;
   wire a_gc    = wb_adr_i == GPTB_OFS_GCTL;
   wire a_wd    = wb_adr_i == GPTB_OFS_WDCTL;
   wire a_rl    = wb_adr_i == GPTB_OFS_REL_LO;
   wire a_rh    = wb_adr_i == GPTB_OFS_REL_HI;
   wire a_st    = wb_adr_i == GPTB_OFS_INTST;
   wire a_em    = wb_adr_i == GPTB_OFS_EMU;

   logic [31:0] rdata;
   always_comb begin
      if (wb_adr_i == GPTB_OFS_PID) rdata = GPTB_PID_VALUE;
      else if (a_em) rdata = emu_r;
      else if (a_cl) rdata = cnt_lo_r;
      else if (a_ch) rdata = cnt_hi_r;
      else if (a_pl) rdata = prd_lo_r;
      else if (a_ph) rdata = prd_hi_r;
      else if (a_tc) rdata = tctl_r;
      else if (a_gc) rdata = gctl_r;
      else if (a_wd) rdata = {16'h0000, wdflag_r, wst_r != GPTB_WS_IDLE,
                              14'h0000};
      else if (a_rl) rdata = rel_lo_r;
      else if (a_rh) rdata = rel_hi_r;
      else if (wb_adr_i == GPTB_OFS_CAP_LO) rdata = cap_lo_r;
      else if (wb_adr_i == GPTB_OFS_CAP_HI) rdata = cap_hi_r;
      else if (a_st) rdata = {29'h0000_0000, stat_r};
      else rdata = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Count source and events.
   wire [1:0] tmode = gctl_r[GPTB_GC_TMODE +: 2];
   wire [1:0] md_lo = tctl_r[GPTB_TC_MODE_LO +: 2];
   wire [1:0] md_hi = tctl_r[GPTB_TC_MODE_HI +: 2];
   wire       ext   = (HAS_EXT != 0);
   wire       pin_rise = pin_r[2] ^ pin_r[1] ? 1'b0 :
                         (pin_r[1] & ~pin_lvl_r);
   wire       tick  = (ext && tctl_r[GPTB_TC_EXTCLK]) ? pin_rise : 1'b1;
   wire       wide  = (tmode == GPTB_TM_64) || (tmode == GPTB_TM_WDOG);
   wire       chain = tmode == GPTB_TM_CHAIN;
   wire       md_ok_lo = (md_lo == GPTB_MD_RELOAD) ? ext :
                         (md_lo != GPTB_MD_OFF);
   wire       md_ok_hi = (md_hi == GPTB_MD_RELOAD) ? ext :
                         (md_hi != GPTB_MD_OFF);
   wire       wd_run = wst_r == GPTB_WS_RUN;
   wire       run_lo = (tmode == GPTB_TM_WDOG) ? wd_run :
                       (gctl_r[GPTB_GC_RS_LO] & md_ok_lo & ~done_lo_r);
   wire       run_hi = wide ? run_lo :
                       (gctl_r[GPTB_GC_RS_HI] & md_ok_hi & ~done_hi_r);
   wire       end64 = {cnt_hi_r, cnt_lo_r} == {prd_hi_r, prd_lo_r};
   wire       end_lo = cnt_lo_r == prd_lo_r;
   wire       end_hi = cnt_hi_r == prd_hi_r;
   wire       step_lo = run_lo & tick;
   wire       evt_w  = step_lo & end64;
   wire       evt_l  = step_lo & end_lo;
   // Low half prescales high half when chained.
   wire       step_hi = run_hi & (chain ? evt_l : tick);
   wire       evt_h  = step_hi & end_hi;
   wire       p_lo   = wide ? evt_w : evt_l;
   wire       p_hi   = wide ? evt_w : evt_h;
   wire       wd_exp = (tmode == GPTB_TM_WDOG) & evt_w;
   wire       rd_clr = ext & tctl_r[GPTB_TC_RDRST] & rd & a_cl;
   wire       cap_ev = ext & tctl_r[GPTB_TC_CAPEN] & pin_rise;
   wire [31:0] wdw   = merge({16'h0000, wdkey_r}, wb_dat_i, wb_sel_i);
   wire       key1   = wr & a_wd & wdw[31:16] == GPTB_WD_KEY1;
   wire       key2   = wr & a_wd & wdw[31:16] == GPTB_WD_KEY2;

   ////////////////////////////////////////////////////////////////////////
   // Counters.
   logic [31:0] cnt_lo_nxt, cnt_hi_nxt;
   always_comb begin
      cnt_lo_nxt = cnt_lo_r;
      cnt_hi_nxt = cnt_hi_r;
      if (wide) begin
         if (step_lo) begin
            {cnt_hi_nxt, cnt_lo_nxt} = end64 ? 64'h0 :
                                       {cnt_hi_r, cnt_lo_r} + 64'h1;
         end
      end else begin
         if (step_lo) cnt_lo_nxt = end_lo ? 32'h0 : cnt_lo_r + 32'h1;
         if (step_hi) cnt_hi_nxt = end_hi ? 32'h0 : cnt_hi_r + 32'h1;
      end
      if (wd_exp || rd_clr || (tmode == GPTB_TM_WDOG && key2 &&
                               wdkey_r == GPTB_WD_KEY1)) begin
         cnt_lo_nxt = 32'h0;
         if (wide) cnt_hi_nxt = 32'h0;
      end
      if (wr && a_cl) cnt_lo_nxt = merge(cnt_lo_r, wb_dat_i, wb_sel_i);
      if (wr && a_ch) cnt_hi_nxt = merge(cnt_hi_r, wb_dat_i, wb_sel_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_lo_r <= 32'h0;
         cnt_hi_r <= 32'h0;
      end else begin
         cnt_lo_r <= cnt_lo_nxt;
         cnt_hi_r <= cnt_hi_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Period, reload, one-shot stop and capture.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prd_lo_r  <= 32'h0;
         prd_hi_r  <= 32'h0;
         rel_lo_r  <= 32'h0;
         rel_hi_r  <= 32'h0;
         done_lo_r <= 1'b0;
         done_hi_r <= 1'b0;
      end else begin
         if (wr && a_pl) prd_lo_r <= merge(prd_lo_r, wb_dat_i, wb_sel_i);
         if (wr && a_ph) prd_hi_r <= merge(prd_hi_r, wb_dat_i, wb_sel_i);
         if (wr && a_rl) rel_lo_r <= merge(rel_lo_r, wb_dat_i, wb_sel_i);
         if (wr && a_rh) rel_hi_r <= merge(rel_hi_r, wb_dat_i, wb_sel_i);
         if (p_lo && md_lo == GPTB_MD_RELOAD) begin
            prd_lo_r <= rel_lo_r;
            if (wide) prd_hi_r <= rel_hi_r;
         end
         if (!wide && p_hi && md_hi == GPTB_MD_RELOAD) prd_hi_r <= rel_hi_r;
         // A control write re-arms, but a period end in the same cycle wins.
         if (wr && (a_tc || a_gc)) begin
            done_lo_r <= 1'b0;
            done_hi_r <= 1'b0;
         end
         if (p_lo && md_lo == GPTB_MD_ONCE && tmode != GPTB_TM_WDOG) begin
            done_lo_r <= 1'b1;
         end
         if (p_hi && !wide && md_hi == GPTB_MD_ONCE) done_hi_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_lo_r  <= 32'h0;
         cap_hi_r  <= 32'h0;
         pin_r     <= 3'h0;
         pin_lvl_r <= 1'b0;
      end else begin
         pin_r <= {pin_r[1:0], tim_in_i};
         if (pin_r[2] == pin_r[1]) pin_lvl_r <= pin_r[1];
         if (cap_ev) begin
            cap_lo_r <= cnt_lo_r;
            cap_hi_r <= cnt_hi_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control, status and watchdog.
   gptb_wdst_e wst_nxt;
   always_comb begin
      wst_nxt = wst_r;
      case (wst_r)
         GPTB_WS_IDLE: begin
            if (tmode == GPTB_TM_WDOG && key1 && wdw[GPTB_WD_EN]) begin
               wst_nxt = GPTB_WS_ARMED;
            end
         end
         GPTB_WS_ARMED: begin
            if (key2) wst_nxt = GPTB_WS_RUN;
         end
         GPTB_WS_RUN: begin
            wst_nxt = GPTB_WS_RUN;
         end
         default: wst_nxt = GPTB_WS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tctl_r   <= 32'h0;
         gctl_r   <= 32'h0;
         emu_r    <= 32'h0;
         wdkey_r  <= 16'h0000;
         wdflag_r <= 1'b0;
         stat_r   <= 3'h0;
         wst_r    <= GPTB_WS_IDLE;
      end else begin
         if (wr && a_tc) tctl_r <= merge(tctl_r, wb_dat_i, wb_sel_i);
         if (wr && a_gc && wst_r != GPTB_WS_RUN) begin
            gctl_r <= merge(gctl_r, wb_dat_i, wb_sel_i);
         end
         if (wr && a_em) emu_r <= merge(emu_r, wb_dat_i, wb_sel_i);
         if (wr && a_wd) wdkey_r <= wdw[31:16];
         wst_r <= wst_nxt;
         if (wd_exp) wdflag_r <= 1'b1;
         else if (wr && a_wd && wdw[GPTB_WD_FLAG]) wdflag_r <= 1'b0;
         // Set wins over write-one-to-clear.
         stat_r <= (wr && a_st) ? stat_r & ~wb_dat_i[2:0] : stat_r;
         if (p_lo) stat_r[GPTB_ST_EVT_LO] <= 1'b1;
         if (p_hi) stat_r[GPTB_ST_EVT_HI] <= 1'b1;
         if (cap_ev) stat_r[GPTB_ST_CAP] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs and bus answer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0;
         irq_o      <= 2'h0;
         dma_evt_o  <= 2'h0;
         rto_evt_o  <= 1'b0;
         wdog_rst_o <= 1'b0;
      end else begin
         wb_ack_o   <= req;
         wb_dat_o   <= rd ? rdata : 32'h0;
         irq_o      <= {p_hi, p_lo};
         dma_evt_o  <= {p_hi, p_lo};
         rto_evt_o  <= ext & (p_lo | p_hi);
         wdog_rst_o <= wd_exp;
      end
   end

endmodule // gptb_timer

// [gptb_timer_asserts.sv]
// Checker of bus handshake and event outputs of the timer block.
`timescale 1ns/1ps
module gptb_timer_asserts #(
   parameter int HAS_EXT = 1
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [gptb_pkg::GPTB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   input  wire logic [31:0]                  wb_dat_o,
   input  wire logic                         wb_ack_o,
   input  wire logic                         tim_in_i,
   input  wire logic [1:0]                   irq_o,
   input  wire logic [1:0]                   dma_evt_o,
   input  wire logic                         rto_evt_o,
   input  wire logic                         wdog_rst_o
);
   import gptb_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
      wb_ack_o) else $error("Request not acknowledged after one cycle.");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge held longer than one cycle.");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("Acknowledge without a request.");
   rdata_idle_a: assert property (!(wb_ack_o && !wb_we_i) |->
      wb_dat_o == 32'h0) else $error("Read data outside read acknowledge.");
   dma_sync_a: assert property (dma_evt_o == irq_o)
      else $error("DMA event differs from interrupt.");
   rto_event_a: assert property (rto_evt_o == (irq_o != 2'h0))
      else $error("Output event differs from period events.");
   wdog_pulse_a: assert property (wdog_rst_o |=> !wdog_rst_o)
      else $error("Watchdog reset longer than one cycle.");
   reset_quiet_a: assert property ($fell(rst_i) |->
      (irq_o == 2'h0 && !wb_ack_o && !wdog_rst_o))
      else $error("Outputs active right after reset.");
   ////////////////////////////////////////////////////////////////////////
   cov_lo: cover property (irq_o[0]);
   cov_hi: cover property (irq_o[1]);
   cov_wd: cover property (wdog_rst_o);
endmodule // gptb_timer_asserts
bind gptb_timer gptb_timer_asserts #(.HAS_EXT(HAS_EXT)) u_gptb_timer_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .tim_in_i(tim_in_i), .irq_o(irq_o), .dma_evt_o(dma_evt_o),
   .rto_evt_o(rto_evt_o), .wdog_rst_o(wdog_rst_o));

// [tb_top.sv]
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
   import gptb_pkg::*;
   logic         clk_i    = 1'b0;
   logic         rst_i    = 1'b1;
   logic         wb_cyc_i = 1'b0;
   logic         wb_stb_i = 1'b0;
   logic         wb_we_i  = 1'b0;
   logic [7:0]   wb_adr_i = 8'h00;
   logic [3:0]   wb_sel_i = 4'hF;
   logic [31:0]  wb_dat_i = 32'h0;
   logic         tim_in_i = 1'b0;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   logic [1:0]   irq_o;
   logic [1:0]   dma_evt_o;
   logic         rto_evt_o;
   logic         wdog_rst_o;
   int           fails = 0;
   int           total_checks = 0;
   int           ev_lo = 0;
   int           n0;
   int           g;
   gptb_timer #(.HAS_EXT(1)) u_gptb_timer (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tim_in_i(tim_in_i),
      .irq_o(irq_o), .dma_evt_o(dma_evt_o), .rto_evt_o(rto_evt_o),
      .wdog_rst_o(wdog_rst_o));
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (irq_o[0] === 1'b1) ev_lo++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wb_xfer(input logic we, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      if (n >= 50) fails++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb_xfer(1'b1, a, d, r);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      logic [31:0] r;
      wb_xfer(1'b0, a, 32'h0, r);
      `CHK(r & m, e)
   endtask
   task automatic cfg(input logic [31:0] plo, phi, tc, gc);
      wr(GPTB_OFS_GCTL, 32'h0);
      wr(GPTB_OFS_CNT_LO, 32'h0);
      wr(GPTB_OFS_CNT_HI, 32'h0);
      wr(GPTB_OFS_PRD_LO, plo);
      wr(GPTB_OFS_PRD_HI, phi);
      wr(GPTB_OFS_TCTL, tc);
      wr(GPTB_OFS_GCTL, gc);
   endtask
   task automatic gap(input int b, output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
      end while (irq_o[b] !== 1'b1 && c < 200);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(GPTB_OFS_PID, '1, GPTB_PID_VALUE);
      wr(GPTB_OFS_PID, 32'h0);
      rd_chk(GPTB_OFS_PID, '1, GPTB_PID_VALUE);
      wr(GPTB_OFS_EMU, 32'h5A5A_0F0F);
      rd_chk(GPTB_OFS_EMU, '1, 32'h5A5A_0F0F);
      rd_chk(8'h08, '1, 32'h0);
      cfg(32'h3, 32'h7, 32'h0002_0002, 32'h7);
      gap(0, g);
      gap(0, g);
      `CHK(g, 32'h4)
      gap(1, g);
      gap(1, g);
      `CHK(g, 32'h8)
      cfg(32'h1, 32'h2, 32'h0002_0002, 32'hF);
      gap(1, g);
      gap(1, g);
      `CHK(g, 32'h6)
      cfg(32'h5, 32'h0, 32'h1, 32'h1);
      n0 = ev_lo;
      repeat (60) @(posedge clk_i);
      `CHK(ev_lo - n0, 32'h1)
      wr(GPTB_OFS_REL_LO, 32'h5);
      wr(GPTB_OFS_REL_HI, 32'h0);
      cfg(32'h2, 32'h0, 32'h3, 32'h1);
      gap(0, g);
      gap(0, g);
      `CHK(g, 32'h6)
      cfg(32'h1, 32'h0, 32'h902, 32'h5);
      n0 = ev_lo;
      repeat (6) begin
         tim_in_i <= 1'b1;
         repeat (8) @(posedge clk_i);
         tim_in_i <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
      `CHK(ev_lo - n0, 32'h3)
      rd_chk(GPTB_OFS_INTST, 32'h4, 32'h4);
      wr(GPTB_OFS_INTST, 32'h7);
      rd_chk(GPTB_OFS_INTST, 32'h7, 32'h0);
      cfg(32'hFF, 32'h0, 32'h400, 32'h4);
      wr(GPTB_OFS_CNT_LO, 32'h9);
      rd_chk(GPTB_OFS_CNT_LO, '1, 32'h9);
      rd_chk(GPTB_OFS_CNT_LO, '1, 32'h0);
      cfg(32'h14, 32'h0, 32'h0, 32'h8);
      wr(GPTB_OFS_WDCTL, {GPTB_WD_KEY1, 16'h4000});
      wr(GPTB_OFS_WDCTL, {GPTB_WD_KEY2, 16'h4000});
      wr(GPTB_OFS_GCTL, 32'h0);
      rd_chk(GPTB_OFS_GCTL, 32'hF, 32'h8);
      g = 0;
      while (wdog_rst_o !== 1'b1 && g < 100) begin
         @(posedge clk_i);
         g++;
      end
      `CHK(g < 100, 1'b1)
      rd_chk(GPTB_OFS_WDCTL, 32'h8000, 32'h8000);
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop;
   end
endmodule // tb_top
